// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import twee_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic wp = 1'b0;
    logic scl_clk, sda_low, sda_o, sda_oe_n, sda_i;
    logic ack;
    logic [7:0] rd;
    int n;
    int failures = 0;
    int checks_done = 0;
    always #12.5 mclk = !mclk;
    // Pull-up wire: low if either party pulls
    assign sda_i = !sda_low && sda_oe_n;
    twee_host_model u_host (.scl_clk(scl_clk), .sda_low(sda_low), .sda(sda_i));
    twee_top #(.WR_CYCLES(400), .FIFO_DEPTH(8)) u_dut (
        .mclk(mclk), .rst_n(rst_n), .scl_clk(scl_clk), .sda_i(sda_i),
        .wp(wp), .sda_o(sda_o), .sda_oe_n(sda_oe_n)
    );
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            failures++;
        end
    endtask
    task automatic sel(input logic [10:0] a, input logic rw);
        u_host.start_c();
        u_host.put_byte({4'hA, a[10:8], rw}, ack);
    endtask
    task automatic set_addr(input logic [10:0] a);
        sel(a, 1'b0);
        chk(8'(ack), 8'h01);
        u_host.put_byte(a[7:0], ack);
        chk(8'(ack), 8'h01);
    endtask
    task automatic rd_at(input logic [10:0] a, input logic [7:0] exp);
        set_addr(a);
        sel(a, 1'b1);
        chk(8'(ack), 8'h01);
        u_host.get_byte(1'b1, rd);
        u_host.stop_c();
        chk(rd, exp);
    endtask
    // Bounded so a device that never frees up cannot hang the run
    task automatic poll();
        n = 0;
        ack = 1'b0;
        while (ack !== 1'b1 && n < 20)
        begin
            sel(11'h000, 1'b0);
            u_host.stop_c();
            n++;
        end
    endtask
    task automatic t_bad();
        logic [3:0] code [4] = '{4'h0, 4'h5, 4'hB, 4'hE};
        foreach (code[i])
        begin
            u_host.start_c();
            u_host.put_byte({code[i], 4'h0}, ack);
            chk(8'(ack), 8'h00);
            u_host.stop_c();
        end
    endtask
    task automatic t_page();
        set_addr(11'h23E);
        for (int i = 0; i < 3; i++)
        begin
            u_host.put_byte(8'hA1 + 8'h11 * 8'(i), ack);
            chk(8'(ack), 8'h01);
        end
        u_host.stop_c();
        poll();
        chk(8'(n > 1), 8'h01);
        chk(8'(n < 5), 8'h01);
        rd_at(11'h23E, 8'hA1);
        rd_at(11'h23F, 8'hB2);
        rd_at(11'h230, 8'hC3);
    endtask
    task automatic t_wp();
        @(posedge mclk) #1 wp = 1'b1;
        set_addr(11'h23E);
        u_host.put_byte(8'h5A, ack);
        chk(8'(ack), 8'h01);
        u_host.stop_c();
        poll();
        chk(8'(n), 8'h01);
        @(posedge mclk) #1 wp = 1'b0;
        rd_at(11'h23E, 8'hA1);
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge mclk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge mclk);
        chk(8'(sda_oe_n), 8'h01);
        chk(8'(sda_o), 8'h00);
        t_bad();
        t_page();
        t_wp();
        test_done();
    end
    initial
    begin
        #1_000_000;
        failures++;
        test_done();
    end
endmodule // tb_top

// [twee_consts.svh]
`ifndef TWEE_CONSTS_SVH
`define TWEE_CONSTS_SVH
// Functional notes
// RULE1: Capture bits on bus clock rising edge, change output bits on falling.
// RULE2: Data line is open drain: only pulled low, otherwise released.
// RULE3: No address-select pins; only one such memory per bus.
// RULE4: Write-protect low allows normal access; high protects whole array.
// RULE5: 128 pages of 16 bytes, any byte picked by 11-bit address.
// RULE6: Page writes of up to 16 bytes, partial pages allowed.
// RULE7: After write sequence ends, self-timed programming finishes within 5 ms.
// RULE8: Select byte is 1010, three page bits, then read/write bit.
// RULE9: Acknowledge each received byte by pulling data low on ninth clock.
// RULE10: Page write increments only low four address bits, wrapping in page.
// RULE11: During programming ignore inputs and refuse select byte; host polls.
// RULE12: Write-protected writes are acknowledged but change nothing, no programming.
`define TWEE_MCLK_NS 32'h0000_0019
`define TWEE_TWR_MS 32'h0000_0005
`define TWEE_NS_PER_MS 32'h000F_4240
`define TWEE_TWR_CYC ((`TWEE_TWR_MS * `TWEE_NS_PER_MS) / `TWEE_MCLK_NS)
`define TWEE_AW 11
`define TWEE_COL_W 4
`define TWEE_PAGE_W 7
`define TWEE_PAGES 8'h80
`define TWEE_PAGE_BYTES 5'h10
`define TWEE_FIFO_D 8
`define TWEE_DEV_CODE 4'hA
`define TWEE_BIT_LAST 4'h7
`define TWEE_BIT_ACK 4'h8
`define TWEE_SY_SCL 0
`define TWEE_SY_SDA 1
`define TWEE_SY_WP 2
`define TWEE_SY_TGL 3
`endif

// [twee_host_model.sv]
`timescale 1ns/1ps
// Sole memory on this bus, no address pins to tell parts apart
module twee_host_model (
    output logic scl_clk,
    output logic sda_low,
    input wire logic sda
);
    localparam int Q = 112;
    initial
    begin
        scl_clk = 1'b1;
        sda_low = 1'b0;
    end
    task automatic start_c();
        if (!scl_clk)
        begin
            #Q sda_low = 1'b0;
            #Q scl_clk = 1'b1;
            #(2 * Q);
        end
        sda_low = 1'b1;
        #(2 * Q) scl_clk = 1'b0;
    endtask
    // Data moves mid-low so setup and hold both exceed 100 ns
    task automatic bit_x(input logic b, output logic r);
        #Q sda_low = !b;
        #Q scl_clk = 1'b1;
        #Q r = sda;
        #Q scl_clk = 1'b0;
    endtask
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(1'b1, d[i]);
        bit_x(last, r);
    endtask
    task automatic stop_c();
        #Q sda_low = 1'b1;
        #Q scl_clk = 1'b1;
        #(2 * Q) sda_low = 1'b0;
        #(4 * Q);
    endtask
endmodule // twee_host_model

// [twee_pkg.sv]
`include "twee_consts.svh"
package twee_pkg;
    typedef enum logic [2:0] {
        TWEE_IDLE = 3'b000,
        TWEE_DEV = 3'b001,
        TWEE_ADDR = 3'b010,
        TWEE_WR = 3'b011,
        TWEE_RD = 3'b100
    } twee_state_e;
    typedef struct packed {
        logic [`TWEE_COL_W-1:0] col;
        logic [7:0] data;
    } twee_wr_s;
endpackage

// [twee_top.sv]
`timescale 1ns/1ps
`include "twee_consts.svh"
module twee_fifo #(
    parameter int W = 12,
    parameter int D = `TWEE_FIFO_D
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = $clog2(D);
    logic [W-1:0] buf_mem [0:D-1];
    logic [PW:0] wp_reg, wp_next, rp_reg, rp_next;
    logic do_wr, do_rd;
    always_comb
    begin
        in_ready = (wp_reg ^ rp_reg) != {1'b1, {PW{1'b0}}};
        out_valid = wp_reg != rp_reg;
        out_data = buf_mem[rp_reg[PW-1:0]];
        do_wr = in_valid && in_ready;
        do_rd = out_valid && out_ready;
        wp_next = do_wr ? wp_reg + 1'b1 : wp_reg;
        rp_next = do_rd ? rp_reg + 1'b1 : rp_reg;
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp_reg <= '0;
            rp_reg <= '0;
        end
        else
        begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
        end
    end
    always_ff @(posedge clk)
    begin
        if (do_wr)
            buf_mem[wp_reg[PW-1:0]] <= in_data;
    end
endmodule // twee_fifo

module twee_top #(
    parameter int WR_CYCLES = `TWEE_TWR_CYC,
    parameter int FIFO_DEPTH = `TWEE_FIFO_D
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic scl_clk,
    input wire logic sda_i,
    input wire logic wp,
    output logic sda_o,
    output logic sda_oe_n
);
    import twee_pkg::*;
    localparam int CW = $clog2(WR_CYCLES + 1);
    localparam int AW = `TWEE_AW;

    function automatic logic [AW-1:0] twee_addr_inc(
        input logic [AW-1:0] a,
        input logic in_page
    );
        logic [AW-1:0] n;
        n = a + 11'h001;
        if (in_page)
            n[AW-1:`TWEE_COL_W] = a[AW-1:`TWEE_COL_W];
        return n;
    endfunction

    // Link side: the bus clock itself samples each data bit [RULE1]
    logic lk_bit_reg, lk_bit_next, lk_tgl_reg, lk_tgl_next;
    always_comb
    begin
        lk_bit_next = sda_i;
        lk_tgl_next = ~lk_tgl_reg;
    end
    always_ff @(posedge scl_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lk_bit_reg <= 1'b0;
            lk_tgl_reg <= 1'b0;
        end
        else
        begin
            lk_bit_reg <= lk_bit_next;
            lk_tgl_reg <= lk_tgl_next;
        end
    end

    // Two-stage synchronisers plus one history stage for edges
    logic [3:0] sy1_reg, sy2_reg, sy1_next, sy2_next;
    logic [3:0] hist_reg, hist_next;
    always_comb
    begin
        sy1_next = {lk_tgl_reg, wp, sda_i, scl_clk};
        sy2_next = sy1_reg;
        hist_next = sy2_reg;
    end
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sy1_reg <= 4'h3;
            sy2_reg <= 4'h3;
            hist_reg <= 4'h3;
        end
        else
        begin
            sy1_reg <= sy1_next;
            sy2_reg <= sy2_next;
            hist_reg <= hist_next;
        end
    end

    logic scl_s, scl_h, sda_s, sda_h, wp_s;
    logic start_ev, stop_ev, rise_ev, fall_ev;
    always_comb
    begin
        scl_s = sy2_reg[`TWEE_SY_SCL];
        scl_h = hist_reg[`TWEE_SY_SCL];
        sda_s = sy2_reg[`TWEE_SY_SDA];
        sda_h = hist_reg[`TWEE_SY_SDA];
        wp_s = sy2_reg[`TWEE_SY_WP];
        start_ev = scl_s && scl_h && sda_h && !sda_s;
        stop_ev = scl_s && scl_h && !sda_h && sda_s;
        // Bit is stable for a whole bus period after its toggle
        rise_ev = sy2_reg[`TWEE_SY_TGL] ^ hist_reg[`TWEE_SY_TGL];
        fall_ev = scl_h && !scl_s;
    end

    // Array: 128 pages x 16 bytes, 11-bit byte address [RULE5]
    logic [7:0] mem [0:(1 << AW)-1];
    logic [7:0] lat_data [0:`TWEE_PAGE_BYTES-1];

    twee_state_e st_reg, st_next;
    logic [3:0] bit_reg, bit_next;
    logic [7:0] rx_reg, rx_next, tx_reg, tx_next, byte_in;
    logic ack_reg, ack_next, rd_reg, rd_next, oe_n_reg, oe_n_next;
    logic [AW-1:0] addr_reg, addr_next;
    logic [`TWEE_PAGE_W-1:0] page_reg, page_next;
    logic arm_reg, arm_next, pend_reg, pend_next, busy_reg, busy_next;
    logic [CW-1:0] wcnt_reg, wcnt_next;
    logic [`TWEE_PAGE_BYTES-1:0] vld_reg, vld_next;
    logic push, pop, f_in_rdy, f_out_vld, drive, mem_we;
    twee_wr_s push_d, pop_d;

    // Stalls while programming; it drains during the sequence, so a long page never fills it
    twee_fifo #(
        .W($bits(twee_wr_s)),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .clk(mclk),
        .rst_n(rst_n),
        .in_valid(push),
        .in_ready(f_in_rdy),
        .in_data(push_d),
        .out_valid(f_out_vld),
        .out_ready(!busy_reg),
        .out_data(pop_d)
    );

    always_comb
    begin
        st_next = st_reg;
        bit_next = bit_reg;
        rx_next = rx_reg;
        tx_next = tx_reg;
        ack_next = ack_reg;
        rd_next = rd_reg;
        oe_n_next = oe_n_reg;
        addr_next = addr_reg;
        page_next = page_reg;
        arm_next = arm_reg;
        pend_next = pend_reg;
        busy_next = busy_reg;
        wcnt_next = wcnt_reg;
        vld_next = vld_reg;
        push = 1'b0;
        push_d = '0;
        drive = 1'b0;
        byte_in = {rx_reg[6:0], lk_bit_reg};
        pop = f_out_vld && !busy_reg;
        mem_we = busy_reg && (wcnt_reg < CW'(`TWEE_PAGE_BYTES))
            && vld_reg[wcnt_reg[`TWEE_COL_W-1:0]];
        if (start_ev)
        begin
            st_next = TWEE_DEV;
            bit_next = 4'h0;
            oe_n_next = 1'b1;
        end
        else if (stop_ev)
        begin
            st_next = TWEE_IDLE;
            oe_n_next = 1'b1;
            // Programming starts only once the sequence has ended [RULE7]
            if (pend_reg)
                arm_next = 1'b1;
        end
        else if (rise_ev && st_reg != TWEE_IDLE)
        begin
            if (bit_reg != `TWEE_BIT_ACK)
            begin
                bit_next = bit_reg + 4'h1;
                rx_next = byte_in;
                tx_next = {tx_reg[6:0], 1'b1};
            end
            else
                bit_next = 4'h0;
            if (bit_reg == `TWEE_BIT_LAST)
            begin
                unique case (st_reg)
                    TWEE_DEV:
                    begin
                        // Select byte: code, page bits, read flag [RULE8]
                        // Refused while programming is armed or running [RULE11]
                        if (byte_in[7:4] == `TWEE_DEV_CODE
                            && !busy_reg && !arm_reg)
                        begin
                            ack_next = 1'b1;
                            rd_next = byte_in[0];
                            addr_next[AW-1:8] = byte_in[3:1];
                        end
                        else
                        begin
                            ack_next = 1'b0;
                            st_next = TWEE_IDLE;
                        end
                    end
                    TWEE_ADDR:
                    begin
                        addr_next[7:0] = byte_in;
                        page_next = {addr_reg[AW-1:8], byte_in[7:4]};
                        ack_next = 1'b1;
                    end
                    TWEE_WR:
                    begin
                        // Protected bytes are acked but dropped [RULE4] [RULE12]
                        // Full buffer shows as a refused byte
                        ack_next = wp_s || f_in_rdy;
                        push = !wp_s;
                        push_d.col = addr_reg[`TWEE_COL_W-1:0];
                        push_d.data = byte_in;
                        if (!wp_s && f_in_rdy)
                            pend_next = 1'b1;
                        if (wp_s || f_in_rdy)
                            addr_next = twee_addr_inc(addr_reg, 1'b1); // [RULE10]
                    end
                    default:
                        ack_next = 1'b0;
                endcase
            end
            else if (bit_reg == `TWEE_BIT_ACK)
            begin
                if (st_reg == TWEE_DEV)
                    st_next = rd_reg ? TWEE_RD : TWEE_ADDR;
                else if (st_reg == TWEE_ADDR)
                    st_next = TWEE_WR;
                if (st_reg == TWEE_RD && lk_bit_reg)
                    st_next = TWEE_IDLE;
                else if ((st_reg == TWEE_DEV && rd_reg)
                    || st_reg == TWEE_RD)
                begin
                    tx_next = mem[addr_reg];
                    addr_next = twee_addr_inc(addr_reg, 1'b0);
                end
            end
        end
        // Outputs change after the bus clock falls, or release on start or stop [RULE1]
        if (fall_ev && !start_ev && !stop_ev)
        begin
            if (st_reg == TWEE_RD)
                drive = bit_reg != `TWEE_BIT_ACK && !tx_reg[7];
            else if (st_reg != TWEE_IDLE)
                drive = bit_reg == `TWEE_BIT_ACK && ack_reg; // [RULE9]
            oe_n_next = !drive; // [RULE2]
        end
        if (pop)
            vld_next[pop_d.col] = 1'b1;
        if (arm_reg && !f_out_vld)
        begin
            arm_next = 1'b0;
            pend_next = 1'b0;
            busy_next = 1'b1;
            wcnt_next = '0;
        end
        else if (busy_reg)
        begin
            // Latched bytes go first, the rest is the timed cycle [RULE7]
            wcnt_next = wcnt_reg + 1'b1;
            if (wcnt_reg == CW'(WR_CYCLES - 1))
            begin
                busy_next = 1'b0;
                vld_next = '0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= TWEE_IDLE;
            bit_reg <= 4'h0;
            rx_reg <= 8'h00;
            tx_reg <= 8'hFF;
            ack_reg <= 1'b0;
            rd_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            addr_reg <= '0;
            page_reg <= '0;
            arm_reg <= 1'b0;
            pend_reg <= 1'b0;
            busy_reg <= 1'b0;
            wcnt_reg <= '0;
            vld_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
            bit_reg <= bit_next;
            rx_reg <= rx_next;
            tx_reg <= tx_next;
            ack_reg <= ack_next;
            rd_reg <= rd_next;
            oe_n_reg <= oe_n_next;
            addr_reg <= addr_next;
            page_reg <= page_next;
            arm_reg <= arm_next;
            pend_reg <= pend_next;
            busy_reg <= busy_next;
            wcnt_reg <= wcnt_next;
            vld_reg <= vld_next;
        end
    end

    // Page latch collects partial pages; only marked bytes are programmed
    always_ff @(posedge mclk)
    begin
        if (pop)
            lat_data[pop_d.col] <= pop_d.data; // [RULE6]
        if (mem_we)
            mem[{page_reg, wcnt_reg[`TWEE_COL_W-1:0]}]
                <= lat_data[wcnt_reg[`TWEE_COL_W-1:0]];
    end

    // Open drain: data output is a constant low, only the enable moves
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            sda_o <= 1'b0;
        else
            sda_o <= 1'b0;
    end
    assign sda_oe_n = oe_n_reg;
endmodule // twee_top

// [twee_top_asserts.sv]
`timescale 1ns/1ps
module twee_chk #(
    parameter int WR_CYCLES = 64,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic scl_clk,
    input wire logic sda_i,
    input wire logic wp,
    input wire logic sda_o,
    input wire logic sda_oe_n
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    a_data_zero: assert property (sda_o == 1'b0)
        else $error("data value not low");
    a_reset_free: assert property ($rose(rst_n) |-> sda_oe_n ##1 sda_oe_n)
        else $error("line driven after reset");
    a_change_low: assert property ($changed(sda_oe_n) |-> !scl_clk || sda_oe_n)
        else $error("line pulled while clock high");
    // Synchroniser delay is 3 edges; one edge of slack for phase
    a_change_late: assert property ($changed(sda_oe_n) && !scl_clk |->
        !$past(scl_clk) && !$past(scl_clk, 2) &&
        ($past(scl_clk, 3) || $past(scl_clk, 4)))
        else $error("output change not tied to clock fall");
    a_hold_low: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*8])
        else $error("low level not held");
    a_hold_rel: assert property ($rose(sda_oe_n) && !scl_clk |-> sda_oe_n [*8])
        else $error("release not held");
    a_start_rel: assert property (scl_clk && $past(scl_clk) && $fell(sda_i)
        |-> sda_oe_n [*8])
        else $error("line pulled after start");
    a_stop_rel: assert property (scl_clk && $past(scl_clk) && $rose(sda_i)
        |-> sda_oe_n [*8])
        else $error("line pulled after stop");
    c_ack: cover property ($fell(sda_oe_n));
    c_start: cover property (scl_clk && $fell(sda_i));
    c_stop: cover property (scl_clk && $rose(sda_i));
endmodule // twee_chk

bind twee_top twee_chk #(.WR_CYCLES(WR_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (
    .mclk(mclk), .rst_n(rst_n), .scl_clk(scl_clk), .sda_i(sda_i),
    .wp(wp), .sda_o(sda_o), .sda_oe_n(sda_oe_n)
);
